// File: src/link_ctrl_cfg.svh
// Offsets, field positions, reset values and timing counts
`ifndef LINK_CTRL_CFG_SVH
`define LINK_CTRL_CFG_SVH
// Device configuration port
`define CFG_ADDR_W          12
`define TS_CTRL_OFS         12'h160
`define LINK_EN_OFS         12'h200
`define OUT_MODE_OFS        12'h201
`define MF_LEN_OFS          12'h202
`define TS_CTRL_RST         8'h00
`define LINK_EN_RST         8'h01
`define OUT_MODE_RST        8'h00
`define MF_LEN_RST          8'h1f
`define EN_BIT              0
`define MODE_MSB            5
`define MODE_64B_FIRST      6'h20
`define KSCALE_64B          9'h100
// Sample path
`define CONV_W              12
`define SAMPLE_W            16
`define FRAME_DIV           4
// Controller registers on AHB-Lite
`define HOST_CMD_OFS        2'h0
`define HOST_STAT_OFS       2'h1
`define HOST_CTRL_OFS       2'h2
`define CMD_WR_BIT          31
`define CMD_DATA_LSB        16
`define STAT_BUSY_BIT       0
`define STAT_REFUSED_BIT    1
`define STAT_RDATA_LSB      8
`define CTRL_CAL_BIT        0
`define CTRL_TSRX_BIT       1
`endif

// File: src/link_ctrl_pkg.sv
// Types shared by both ends of the configuration link
`include "link_ctrl_cfg.svh"
package link_ctrl_pkg;
    typedef logic [`CFG_ADDR_W-1:0] cfgAddr_t;
    typedef logic [7:0]             cfgByte_t;
    typedef logic [`CONV_W-1:0]     convSample_t;
    typedef logic [`SAMPLE_W-1:0]   txSample_t;
endpackage : link_ctrl_pkg

// File: src/link_cfg_if.sv
// Configuration port between controller and converter link
interface link_cfg_if;
    import link_ctrl_pkg::*;
    logic     cfgReq;
    logic     cfgWrite;
    cfgAddr_t cfgAddr;
    cfgByte_t cfgWdata;
    logic     cfgAck;
    cfgByte_t cfgRdata;
    logic     calEnable;
    logic     timestampRxEnable;

    modport device (
        input  cfgReq, cfgWrite, cfgAddr, cfgWdata, calEnable,
        input  timestampRxEnable,
        output cfgAck, cfgRdata
    );
    modport host (
        output cfgReq, cfgWrite, cfgAddr, cfgWdata, calEnable,
        output timestampRxEnable,
        input  cfgAck, cfgRdata
    );
endinterface : link_cfg_if

// File: src/pin_sync.sv
// Two-flop synchroniser for asynchronous pin levels
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         resetn,
    // Levels
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinOut
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } syncState_t;

    syncState_t cur;
    syncState_t next_cur;

    always_comb begin
        next_cur        = cur;
        next_cur.meta   = pinIn;
        next_cur.stable = cur.meta;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign pinOut = cur.stable;
endmodule : pin_sync

// File: src/link_dev_end.sv
// Converter end: link config registers, timestamp LSB and frame counter
// What the document requires of this link
// R01 - Timestamp bit rides in every sample LSB
// R02 - Timestamp latency equals sample latency
// R03 - Software enables timestamp receiver with insertion
// R04 - Wide field keeps converter sample intact
// R05 - Lane alignment always advertises zero control bits
// R06 - Software writes reserved bits as reset value; controller end passes OUT_MODE_OFS bits 7:6 as written
// R07 - Link enable bit, resets to one
// R08 - Software disables link before other changes
// R09 - Disabled link: reset, serializers off, clocks gated
// R10 - Disabled link: frame counter reset, SYSREF ignored
// R11 - Software enables calibration before link
// R12 - Software disables link before calibration
// R13 - Six-bit output mode field, bits 7:6 reserved
// R14 - Mode changes only with link and calibration off
// R15 - Multiframe length register, reset 0x1f
// R16 - Frames per multiframe programmed minus one
// R17 - 64B/66B modes derive K from mode
// R18 - Registers reset, reads return last write
module link_dev_end
    import link_ctrl_pkg::*;
#(
    parameter int FRAME_DIV = `FRAME_DIV
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Configuration port
    link_cfg_if.device       cfg,
    // Converter samples, same clock
    input  wire convSample_t sampleIn,
    input  wire logic        sampleValid,
    // Asynchronous pins
    input  wire logic        timestampPin,
    input  wire logic        sysrefPin,
    // Serial side
    output txSample_t        txSample,
    output logic             txValid,
    output logic             laneResetN,
    output logic             serializerPowerDown,
    output logic             linkClkEnable,
    output logic [7:0]       multiframeCount,
    output logic             multiframeStart,
    output logic [7:0]       effectiveKMinus1,
    output logic [7:0]       ilaControlBits
);
    localparam int PAD_W = `SAMPLE_W - `CONV_W;

    typedef struct packed {
        cfgByte_t    tsCtrl;
        cfgByte_t    linkEn;
        cfgByte_t    outMode;
        cfgByte_t    kMinus1;
        logic        ack;
        cfgByte_t    rdata;
        convSample_t sampD1;
        convSample_t sampD2;
        logic        validD1;
        logic        validD2;
        txSample_t   txSample;
        logic        txValid;
        logic        laneResetN;
        logic        serPd;
        logic        clkEn;
        logic [7:0]  divCnt;
        logic [7:0]  mfCnt;
        logic        mfStart;
        logic        sysrefPrev;
        logic [7:0]  effK;
        logic [7:0]  ilaCs;
    } devState_t;

    devState_t cur;
    devState_t next_cur;
    logic      tsSync;
    logic      sysrefSync;

    // Effective K-1: register in 8B/10B, 256*E/F-1 in 64B/66B (E=1)
    function automatic logic [7:0] kEffMinus1(input cfgByte_t mode,
                                              input cfgByte_t km1);
        logic [8:0] k;
        k = 9'h0;
        if (mode[`MODE_MSB:0] >= `MODE_64B_FIRST) begin
            k = `KSCALE_64B >> mode[1:0]; // R17
            return 8'(k - 9'h1);
        end
        return km1; // R16
    endfunction : kEffMinus1

    function automatic cfgByte_t readReg(input devState_t s,
                                         input cfgAddr_t a);
        case (a)
            `TS_CTRL_OFS:  return s.tsCtrl;
            `LINK_EN_OFS:  return s.linkEn;
            `OUT_MODE_OFS: return s.outMode;
            `MF_LEN_OFS:   return s.kMinus1;
            default:       return 8'h00;
        endcase
    endfunction : readReg

    // Timestamp and SYSREF are both pins: same two-flop delay
    pin_sync #(
        .W (2)
    ) pin_sync_inst (
        .core_clk (core_clk),
        .resetn   (resetn),
        .pinIn    ({timestampPin, sysrefPin}),
        .pinOut   ({tsSync, sysrefSync})
    );

    always_comb begin
        logic enabled;
        logic tsBit;
        enabled  = cur.linkEn[`EN_BIT];
        tsBit    = 1'b0;
        next_cur = cur;

        // Configuration access, answered one cycle after the request
        next_cur.ack = cfg.cfgReq;
        if (cfg.cfgReq) begin
            next_cur.rdata = readReg(cur, cfg.cfgAddr); // R18
            if (cfg.cfgWrite) begin
                case (cfg.cfgAddr)
                    `TS_CTRL_OFS:  next_cur.tsCtrl  = cfg.cfgWdata;
                    `LINK_EN_OFS:  next_cur.linkEn  = cfg.cfgWdata; // R07
                    `OUT_MODE_OFS: next_cur.outMode = cfg.cfgWdata; // R13
                    `MF_LEN_OFS:   next_cur.kMinus1 = cfg.cfgWdata; // R15
                    default:       next_cur.rdata   = 8'h00;
                endcase
            end
        end

        // Samples delayed to match the pin synchroniser
        next_cur.sampD1  = sampleIn; // R02
        next_cur.sampD2  = cur.sampD1; // R02
        next_cur.validD1 = sampleValid;
        next_cur.validD2 = cur.validD1;

        // Receiver gated by its own enable, as software is asked to set
        if (cur.tsCtrl[`EN_BIT] && cfg.timestampRxEnable) begin
            tsBit = tsSync; // R03
        end

        next_cur.laneResetN = enabled; // R09
        next_cur.serPd      = !enabled; // R09
        next_cur.clkEn      = enabled; // R09
        next_cur.effK       = kEffMinus1(cur.outMode, cur.kMinus1);
        next_cur.ilaCs      = 8'h00; // R05
        next_cur.mfStart    = 1'b0;
        next_cur.sysrefPrev = sysrefSync;

        if (!enabled) begin
            next_cur.txSample = '0; // R09
            next_cur.txValid  = 1'b0; // R09
            next_cur.divCnt   = 8'h00; // R10
            next_cur.mfCnt    = 8'h00; // R10
        end else begin
            next_cur.txValid = cur.validD2;
            if (cur.validD2) begin
                // Sample in the upper bits, marker in the field LSB
                next_cur.txSample = {cur.sampD2, PAD_W'(0)}; // R04
                if (cur.tsCtrl[`EN_BIT]) begin
                    next_cur.txSample[0] = tsBit; // R01
                end
            end
            if (sysrefSync && !cur.sysrefPrev) begin
                // Realign only while enabled
                next_cur.divCnt  = 8'h00; // R10
                next_cur.mfCnt   = 8'h00; // R10
                next_cur.mfStart = 1'b1;
            end else if (cur.divCnt == 8'(FRAME_DIV - 1)) begin
                next_cur.divCnt = 8'h00;
                if (cur.mfCnt >= cur.effK) begin
                    next_cur.mfCnt   = 8'h00; // R17
                    next_cur.mfStart = 1'b1;
                end else begin
                    next_cur.mfCnt = cur.mfCnt + 8'h01;
                end
            end else begin
                next_cur.divCnt = cur.divCnt + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cur            <= '0;
            cur.tsCtrl     <= `TS_CTRL_RST; // R18
            cur.linkEn     <= `LINK_EN_RST; // R07
            cur.outMode    <= `OUT_MODE_RST;
            cur.kMinus1    <= `MF_LEN_RST; // R15
            cur.laneResetN <= 1'b1;
            cur.clkEn      <= 1'b1;
            cur.effK       <= `MF_LEN_RST;
        end else begin
            cur <= next_cur;
        end
    end

    assign cfg.cfgAck          = cur.ack;
    assign cfg.cfgRdata        = cur.rdata;
    assign txSample            = cur.txSample;
    assign txValid             = cur.txValid;
    assign laneResetN          = cur.laneResetN;
    assign serializerPowerDown = cur.serPd;
    assign linkClkEnable       = cur.clkEn;
    assign multiframeCount     = cur.mfCnt;
    assign multiframeStart     = cur.mfStart;
    assign effectiveKMinus1    = cur.effK;
    assign ilaControlBits      = cur.ilaCs;
endmodule : link_dev_end

// File: src/link_host_end.sv
// Controller end: AHB-Lite registers driving the configuration port
module link_host_end
    import link_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Configuration port
    link_cfg_if.host         cfg
);
    typedef struct packed {
        logic        hreadyout;
        logic [31:0] hrdata;
        logic        dWrite;
        logic [1:0]  dReg;
        logic        busy;
        logic        refused;
        cfgByte_t    rdata;
        logic        req;
        logic        wr;
        cfgAddr_t    addr;
        cfgByte_t    wdata;
        logic        calEn;
        logic        tsRxCtl;
        logic        linkShadow;
        logic        tsShadow;
    } hostState_t;

    hostState_t cur;
    hostState_t next_cur;

    always_comb begin
        logic     isWr;
        cfgAddr_t a;
        cfgByte_t d;
        logic     bad;
        isWr     = hwdata[`CMD_WR_BIT];
        a        = hwdata[`CFG_ADDR_W-1:0];
        d        = hwdata[`CMD_DATA_LSB+:8];
        bad      = 1'b0;
        next_cur = cur;
        next_cur.req = 1'b0;

        if (cur.busy && cfg.cfgAck) begin
            next_cur.busy  = 1'b0;
            next_cur.rdata = cfg.cfgRdata;
        end

        // Data phase of a write
        if (cur.dWrite) begin
            next_cur.dWrite = 1'b0;
            if (cur.dReg == `HOST_CMD_OFS && !cur.busy) begin
                if (isWr && a == `LINK_EN_OFS && d[`EN_BIT]
                    && !cur.calEn) begin
                    bad = 1'b1; // R11
                end
                if (isWr && a != `LINK_EN_OFS && cur.linkShadow) begin
                    bad = 1'b1; // R08
                end
                if (isWr && a == `OUT_MODE_OFS && cur.calEn) begin
                    bad = 1'b1; // R14
                end
                next_cur.refused = bad;
                if (!bad) begin
                    if (isWr && (a == `TS_CTRL_OFS || a == `LINK_EN_OFS)) begin
                        d[7:1] = 7'h00; // R06
                    end
                    if (isWr && a == `LINK_EN_OFS) begin
                        next_cur.linkShadow = d[`EN_BIT];
                    end
                    if (isWr && a == `TS_CTRL_OFS) begin
                        next_cur.tsShadow = d[`EN_BIT];
                    end
                    next_cur.busy  = 1'b1;
                    next_cur.req   = 1'b1;
                    next_cur.wr    = isWr;
                    next_cur.addr  = a;
                    next_cur.wdata = d;
                end
            end else if (cur.dReg == `HOST_CTRL_OFS) begin
                if (!hwdata[`CTRL_CAL_BIT] && cur.linkShadow) begin
                    next_cur.refused = 1'b1; // R12
                end else begin
                    next_cur.calEn = hwdata[`CTRL_CAL_BIT];
                end
                next_cur.tsRxCtl = hwdata[`CTRL_TSRX_BIT];
            end
        end

        // Address phase; read data registered for the data phase
        if (hsel && htrans[1] && hready) begin
            next_cur.dWrite = hwrite;
            next_cur.dReg   = haddr[3:2];
            next_cur.hrdata = 32'h0;
            case (haddr[3:2])
                `HOST_STAT_OFS: begin
                    next_cur.hrdata[`STAT_BUSY_BIT]       = cur.busy;
                    next_cur.hrdata[`STAT_REFUSED_BIT]    = cur.refused;
                    next_cur.hrdata[`STAT_RDATA_LSB+:8]   = cur.rdata;
                end
                `HOST_CTRL_OFS: begin
                    next_cur.hrdata[`CTRL_CAL_BIT]  = cur.calEn;
                    next_cur.hrdata[`CTRL_TSRX_BIT] = cur.tsRxCtl;
                end
                default: next_cur.hrdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cur            <= '0;
            cur.hreadyout  <= 1'b1;
            cur.linkShadow <= 1'(`LINK_EN_RST >> `EN_BIT);
        end else begin
            cur <= next_cur;
        end
    end

    assign hreadyout             = cur.hreadyout;
    assign hrdata                = cur.hrdata;
    assign hresp                 = 1'b0;
    assign cfg.cfgReq            = cur.req;
    assign cfg.cfgWrite          = cur.wr;
    assign cfg.cfgAddr           = cur.addr;
    assign cfg.cfgWdata          = cur.wdata;
    assign cfg.calEnable         = cur.calEn;
    assign cfg.timestampRxEnable = cur.tsRxCtl | cur.tsShadow; // R03
endmodule : link_host_end

// File: bench/link_cfg_properties.sv
// Checker for the configuration port between the two link ends
`include "link_ctrl_cfg.svh"
module link_cfg_properties
    import link_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic     core_clk,
    input wire logic     resetn,
    // Configuration port
    input wire logic     cfgReq,
    input wire logic     cfgWrite,
    input wire cfgAddr_t cfgAddr,
    input wire cfgByte_t cfgWdata,
    input wire logic     cfgAck,
    input wire cfgByte_t cfgRdata,
    input wire logic     calEnable,
    input wire logic     timestampRxEnable
);
    cfgByte_t tsR, enR, modeR, kmR, regNow;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // Shadow copy, so readback can be judged without the device body
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            tsR   <= `TS_CTRL_RST;
            enR   <= `LINK_EN_RST;
            modeR <= `OUT_MODE_RST;
            kmR   <= `MF_LEN_RST;
        end else if (cfgReq && cfgWrite) begin
            case (cfgAddr)
                `TS_CTRL_OFS:  tsR <= cfgWdata;
                `LINK_EN_OFS:  enR <= cfgWdata;
                `OUT_MODE_OFS: modeR <= cfgWdata;
                `MF_LEN_OFS:   kmR <= cfgWdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (cfgAddr)
            `TS_CTRL_OFS:  regNow = tsR;
            `LINK_EN_OFS:  regNow = enR;
            `OUT_MODE_OFS: regNow = modeR;
            `MF_LEN_OFS:   regNow = kmR;
            default:       regNow = 8'h00;
        endcase
    end

    sequence reqThenAck;
        cfgReq ##1 cfgAck;
    endsequence

    sequence wrAt(cfgAddr_t a);
        cfgReq && cfgWrite && cfgAddr == a;
    endsequence

    AST_ACK_AFTER_REQ: assert property (cfgReq |=> cfgAck)
        else $error("config ack missing one cycle after request");
    AST_ACK_HAS_CAUSE: assert property (cfgAck |-> $past(cfgReq))
        else $error("config ack without request");
    AST_ONE_OUTSTANDING: assert property (reqThenAck |-> !cfgReq)
        else $error("new request before ack");
    AST_RDATA_MATCH: assert property (
        cfgReq |=> cfgRdata == $past(regNow))
        else $error("config read data differs from register");
    AST_RESERVED_CLEAR: assert property (
        cfgReq && cfgWrite && (cfgAddr == `TS_CTRL_OFS ||
        cfgAddr == `LINK_EN_OFS) |-> cfgWdata[7:1] == 7'h00)
        else $error("reserved bits written nonzero");
    AST_LINK_ON_NEEDS_CAL: assert property (
        wrAt(`LINK_EN_OFS) ##0 cfgWdata[0] |-> calEnable)
        else $error("link enabled without calibration");
    AST_CAL_OFF_LINK_OFF: assert property (
        $fell(calEnable) |-> !enR[0])
        else $error("calibration cleared while link enabled");
    AST_MODE_NEEDS_IDLE: assert property (
        wrAt(`OUT_MODE_OFS) |-> !calEnable && !enR[0])
        else $error("mode changed while link or calibration on");
    AST_OTHER_NEEDS_OFF: assert property (
        cfgReq && cfgWrite && cfgAddr != `LINK_EN_OFS |-> !enR[0])
        else $error("register changed while link enabled");
    AST_TSRX_FOLLOWS: assert property (
        wrAt(`TS_CTRL_OFS) ##0 cfgWdata[0] |-> ##[1:3] timestampRxEnable)
        else $error("timestamp receiver not enabled with insertion");
endmodule : link_cfg_properties

// File: bench/serial_link_enable_and_timestamp_control_tb.sv
// Testbench joining both link ends over the configuration interface
`include "link_ctrl_cfg.svh"
module serial_link_enable_and_timestamp_control_tb
    import link_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk, resetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    convSample_t sampleIn;
    logic        sampleValid, timestampPin, sysrefPin, txValid;
    txSample_t   txSample;
    logic        laneResetN, serializerPowerDown, linkClkEnable;
    logic        multiframeStart, noteRd;
    logic [7:0]  multiframeCount, effectiveKMinus1, ilaControlBits;
    logic [15:0] expQ[$], mskQ[$], txQ[$];
    int          errCount, nTests, seed;
    logic [15:0] seenStat, expTx;
    wire  [15:0] linkCtl  = {13'h0, laneResetN, serializerPowerDown,
                             linkClkEnable};
    wire  [15:0] frameCnt = {7'h0, multiframeStart, multiframeCount};

    link_cfg_if cfgIf();
    link_host_end link_host_end_inst(.core_clk, .resetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
        .hrdata, .hresp, .cfg(cfgIf.host));
    link_dev_end #(.FRAME_DIV(4)) link_dev_end_inst(.core_clk, .resetn,
        .cfg(cfgIf.device), .sampleIn, .sampleValid, .timestampPin,
        .sysrefPin, .txSample, .txValid, .laneResetN, .serializerPowerDown,
        .linkClkEnable, .multiframeCount, .multiframeStart,
        .effectiveKMinus1, .ilaControlBits);
    link_cfg_properties link_cfg_properties_inst(.core_clk, .resetn,
        .cfgReq(cfgIf.cfgReq), .cfgWrite(cfgIf.cfgWrite),
        .cfgAddr(cfgIf.cfgAddr), .cfgWdata(cfgIf.cfgWdata),
        .cfgAck(cfgIf.cfgAck), .cfgRdata(cfgIf.cfgRdata),
        .calEnable(cfgIf.calEnable),
        .timestampRxEnable(cfgIf.timestampRxEnable));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [15:0] seen, exp);
        nTests++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finishTest;
        if (errCount == 0 && nTests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finishTest

    // One single transfer; entered right after a rising edge
    task automatic ahb(input logic wr, input logic [31:0] a, wd,
                       input logic note, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        noteRd <= note;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        noteRd <= 1'b0;
    endtask : ahb

    task automatic dev(input logic wr, input cfgAddr_t a, input cfgByte_t d);
        logic [31:0] r;
        int          i;
        ahb(1'b1, 32'h0, {wr, 7'h00, d, 4'h0, a}, 1'b0, r);
        repeat (3) @(posedge core_clk);
        r = 32'h1;
        for (i = 0; i < 50 && r[0] !== 1'b0; i++)
            ahb(1'b0, 32'h4, 32'h0, 1'b0, r);
    endtask : dev

    task automatic statChk(input logic [15:0] e, m);
        logic [31:0] r;
        expQ.push_back(e);
        mskQ.push_back(m);
        ahb(1'b0, 32'h4, 32'h0, 1'b1, r);
    endtask : statChk

    task automatic devRd(input cfgAddr_t a, input cfgByte_t e);
        dev(1'b0, a, 8'h00);
        statChk({e, 8'h00}, 16'hff03);
    endtask : devRd

    task automatic refusedChk(input logic rf);
        statChk({14'h0, rf, 1'b0}, 16'h0003);
    endtask : refusedChk

    // Results are paired with notes in the order they were made
    always @(posedge core_clk) begin
        if (noteRd === 1'b1 && hreadyout === 1'b1) begin
            seenStat = hrdata[15:0] & mskQ.pop_front();
            check("stat", seenStat, expQ.pop_front());
        end
        if (txValid === 1'b1) begin
            expTx = txQ.size() > 0 ? txQ.pop_front() : 16'hxxxx;
            check("txSample", txSample, expTx);
        end
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        errCount++;
        finishTest();
    end

    initial begin
        cfgByte_t    km;
        logic [31:0] r;
        int          i;
        convSample_t s;
        logic        t;
        seed = 85643;
        {errCount, nTests} = '0;
        {hsel, hwrite, htrans, haddr, hwdata, noteRd} = '0;
        hsize = 3'b010;
        {sampleIn, sampleValid, timestampPin, sysrefPin} = '0;
        resetn = 1'b0;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        devRd(`TS_CTRL_OFS, `TS_CTRL_RST);
        devRd(`LINK_EN_OFS, `LINK_EN_RST);
        devRd(`OUT_MODE_OFS, `OUT_MODE_RST);
        devRd(`MF_LEN_OFS, `MF_LEN_RST);
        dev(1'b1, `MF_LEN_OFS, 8'h05);
        refusedChk(1'b1);
        dev(1'b1, `LINK_EN_OFS, 8'h00);
        refusedChk(1'b0);
        check("linkCtl", linkCtl, 16'h0002);
        // Frame alignment pulses must not reach a disabled link
        for (i = 0; i < 8; i++) begin
            sysrefPin <= (i < 2);
            @(posedge core_clk);
            check("frameCnt", frameCnt, 16'h0000);
        end
        dev(1'b1, `TS_CTRL_OFS, 8'hff);
        devRd(`TS_CTRL_OFS, 8'h01);
        km = cfgByte_t'($random(seed));
        dev(1'b1, `MF_LEN_OFS, km);
        devRd(`MF_LEN_OFS, km);
        dev(1'b1, `LINK_EN_OFS, 8'h01);
        refusedChk(1'b1);
        ahb(1'b1, 32'h8, 32'h1, 1'b0, r);
        dev(1'b1, `LINK_EN_OFS, 8'h01);
        refusedChk(1'b0);
        check("effK", {8'h0, effectiveKMinus1}, {8'h0, km});
        check("ilaCs", {8'h0, ilaControlBits}, 16'h0000);
        check("linkCtl", linkCtl, 16'h0005);
        ahb(1'b1, 32'h8, 32'h0, 1'b0, r);
        refusedChk(1'b1);
        for (i = 0; i < 12; i++) begin
            {s, t} = 13'($random(seed));
            sampleIn <= s;
            sampleValid <= 1'b1;
            timestampPin <= t;
            txQ.push_back({s, 3'h0, t});
            @(posedge core_clk);
        end
        sampleValid <= 1'b0;
        repeat (6) @(posedge core_clk);
        check("txLeft", 16'(txQ.size()), 16'h0000);
        dev(1'b1, `LINK_EN_OFS, 8'h00);
        dev(1'b1, `OUT_MODE_OFS, 8'h21);
        refusedChk(1'b1);
        ahb(1'b1, 32'h8, 32'h0, 1'b0, r);
        dev(1'b1, `OUT_MODE_OFS, 8'h21);
        devRd(`OUT_MODE_OFS, 8'h21);
        ahb(1'b1, 32'h8, 32'h1, 1'b0, r);
        dev(1'b1, `LINK_EN_OFS, 8'h01);
        repeat (2) @(posedge core_clk);
        check("effK64", {8'h0, effectiveKMinus1}, 16'h007f);
        // Enabled link: SYSREF realigns, then a wrap every K frames
        sysrefPin <= 1'b1;
        @(posedge core_clk);
        sysrefPin <= 1'b0;
        i = 0;
        while (multiframeStart !== 1'b1 && i < 8) begin
            @(posedge core_clk);
            i++;
        end
        check("sysrefLag", 16'(i), 16'h0003);
        check("alignCnt", frameCnt, 16'h0100);
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (multiframeStart !== 1'b1 && i < 600);
        check("mfPeriod", 16'(i), 16'h0200);
        check("wrapCnt", frameCnt, 16'h0100);
        finishTest();
    end
endmodule : serial_link_enable_and_timestamp_control_tb
